// >>> verilog/fsp_pkg.sv
// Purpose: Shared constants and types for the flash self-programming controller.
// Assumes: 13-bit word addresses, 64-word pages, 100 MHz CPU clock, 8 MHz RC tick.
// Notes: All numbers used by the logic live here.
package fsp_pkg;
  localparam int PC_W = 13;
  localparam int PAGE_W = 7;
  localparam int WORD_W = 6;
  localparam int BUF_DEPTH = 64;
  localparam int DATA_W = 16;
  localparam int Z_W = 16;
  localparam int Z_PAGE_HI = 13;
  localparam int Z_PAGE_LO = 7;
  localparam int Z_WORD_HI = 6;
  localparam int Z_WORD_LO = 1;
  localparam int Z_BYTE = 0;

  // Area limits
  localparam logic [PC_W-1:0] RWW_END = 13'h17ff;
  localparam logic [PAGE_W-1:0] RWW_PAGES = 7'h60;

  // Boot area start per boot-size fuse value
  localparam logic [1:0] BOOT_SZ_256 = 2'h3;
  localparam logic [1:0] BOOT_SZ_512 = 2'h2;
  localparam logic [1:0] BOOT_SZ_1024 = 2'h1;
  localparam logic [PC_W-1:0] BOOT_START_256 = 13'h1f00;
  localparam logic [PC_W-1:0] BOOT_START_512 = 13'h1e00;
  localparam logic [PC_W-1:0] BOOT_START_1024 = 13'h1c00;
  localparam logic [PC_W-1:0] BOOT_START_2048 = 13'h1800;
  localparam logic [PC_W-1:0] ADDR_ONE = 13'h0001;

  // Register map
  localparam int ADDR_W = 3;
  localparam int REG_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 3'h3;

  // Control register fields
  localparam int CMD_W = 6;
  localparam int CTL_EN = 0;
  localparam int CTL_IE = 7;
  localparam logic [CMD_W-1:0] CMD_FILL = 6'h01;
  localparam logic [CMD_W-1:0] CMD_ERASE = 6'h03;
  localparam logic [CMD_W-1:0] CMD_WRITE = 6'h05;
  localparam logic [CMD_W-1:0] CMD_LOCK = 6'h09;
  localparam logic [CMD_W-1:0] CMD_REEN = 6'h11;
  localparam logic [2:0] CMD_WINDOW = 3'h4;

  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TIMEOUT = 1;

  // Lock bits carried in r0[5:2]
  localparam int LOCK_W = 4;
  localparam int LOCK_LSB = 2;
  localparam logic [LOCK_W-1:0] LOCK_RESET = 4'hf;

  // Programming time
  localparam int CLK_MHZ = 100;
  localparam int RC_KHZ = 8000;
  localparam int PROG_MIN_US = 3700;
  localparam int PROG_MAX_US = 4500;
  localparam int PROG_NOM_US = 4100;
  localparam int PROG_MIN_CYC = PROG_MIN_US * CLK_MHZ;
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
  localparam int PROG_TICKS_DEF = PROG_NOM_US * RC_KHZ / 1000;
  localparam int TICK_W = 16;

  typedef enum logic [1:0] {FSP_OP_NONE, FSP_OP_ERASE, FSP_OP_WRITE, FSP_OP_LOCK} fsp_op_t;
  typedef enum logic {FSP_TMR_IDLE, FSP_TMR_RUN} fsp_tmr_state_t;
endpackage : fsp_pkg

// >>> verilog/fsp_prog_timer.sv
// Purpose: Times one flash erase or write in calibrated RC oscillator ticks.
// Assumes: rc_tick is a one-cycle pulse per RC period, synchronous to clock.
// Notes: Reset only by power-on reset so a started write runs to its end.
`timescale 1ns/10ps
module fsp_prog_timer #(
  parameter int TICKS = fsp_pkg::PROG_TICKS_DEF
) (
  input wire logic clock,
  input wire logic por_n,
  input wire logic start,
  input wire logic rc_tick,
  output logic busy,
  output logic done
);
  fsp_pkg::fsp_tmr_state_t state_reg, state_next;
  logic [fsp_pkg::TICK_W-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic last_tick;

  assign last_tick = rc_tick && (cnt_reg == fsp_pkg::TICK_W'(TICKS - 1));

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    case (state_reg)
      fsp_pkg::FSP_TMR_IDLE: begin
        if (start) begin
          state_next = fsp_pkg::FSP_TMR_RUN;
          cnt_next = '0;
        end
      end
      fsp_pkg::FSP_TMR_RUN: begin
        // CPU clock never advances the count, only the RC tick
        if (last_tick) begin
          state_next = fsp_pkg::FSP_TMR_IDLE;
          done_next = 1'b1;
        end else if (rc_tick) begin
          cnt_next = cnt_reg + fsp_pkg::TICK_W'(1);
        end
      end
      default: state_next = fsp_pkg::FSP_TMR_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      state_reg <= fsp_pkg::FSP_TMR_IDLE;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (state_reg == fsp_pkg::FSP_TMR_RUN);
  assign done = done_reg;

  a_timer_end: assert property (@(posedge clock) disable iff (!por_n)
    (busy && last_tick) |=> (done && !busy))
    else $error("timer did not finish on its last tick");
  a_timer_hold: assert property (@(posedge clock) disable iff (!por_n)
    (busy && !rc_tick) |=> (busy && !done && $stable(cnt_reg)))
    else $error("timer moved without an RC tick");
endmodule : fsp_prog_timer

// >>> verilog/fsp_ctrl.sv
// Purpose: Self-programming control for the program flash, smallest memory variant.
// Assumes: CPU signals spm_exec for one cycle when the store-to-program instruction runs.
// Notes: Operation state uses por_n so a reset mid-write lets the write finish.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// Overview of operation
// - Each erase, page write or lock write lasts 3.7 ms to 4.5 ms.
// - Erase and write timing counts calibrated RC oscillator ticks, not CPU clocks.
// - A reset during a flash write still lets that write finish.
// - Boot-size fuse picks boot start 0x1F00/0x1E00/0x1C00/0x1800; application ends one below.
// - Words 0x0000 to 0x17FF, 96 pages, form the read-while-write area.
// - Words 0x1800 to 0x1FFF, 32 pages; programming them halts the CPU.
// - Program counter is 13 bits; 64-word pages indexed by bits 5 to 0.
// - Erase and write take the page number from pointer bits 13 to 7.
// - Buffer fill uses pointer bits 6 to 1; software zeroes them for page write.
// - Pointer bit 0 is zero for commands; table reads use it as byte select.
// - During erase or write only the no-read-while-write area may be read.
// - Area-busy flag stays set until software re-enables the area.
// - Command with only enable set loads r1r0 into the page buffer.
// - The instruction must follow the command within four cycles, else command clears.
// - Pattern X0000101 selects page write; X0001001 selects lock-bit programming.
// - With interrupt enabled, the request is high while enable is clear.
// - Area-busy clears only by the re-enable command after programming ends.
module fsp_ctrl #(
  parameter int PROG_TICKS = fsp_pkg::PROG_TICKS_DEF
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic por_n,
  input wire logic [fsp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fsp_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fsp_pkg::REG_W-1:0] reg_rdata,
  input wire logic eeprom_write_pending,
  input wire logic spm_exec,
  input wire logic [fsp_pkg::Z_W-1:0] z_ptr,
  input wire logic [fsp_pkg::DATA_W-1:0] r1r0,
  input wire logic rc_tick,
  input wire logic [1:0] boot_size,
  input wire logic [fsp_pkg::PC_W-1:0] fetch_addr,
  output logic fetch_ok,
  output logic cpu_halt,
  input wire logic [fsp_pkg::DATA_W-1:0] tbl_word,
  output logic [fsp_pkg::REG_W-1:0] tbl_byte,
  output logic [fsp_pkg::PC_W-1:0] boot_start,
  output logic [fsp_pkg::PC_W-1:0] app_end,
  output logic [1:0] flash_op,
  output logic [fsp_pkg::PAGE_W-1:0] flash_page,
  output logic flash_go,
  input wire logic [fsp_pkg::WORD_W-1:0] buf_idx,
  output logic [fsp_pkg::DATA_W-1:0] buf_data,
  output logic [fsp_pkg::LOCK_W-1:0] lock_bits,
  output logic spm_irq,
  output logic irq
);
  // Control group, CPU reset
  logic [fsp_pkg::CMD_W-1:0] cmd_reg, cmd_next;
  logic ie_reg, ie_next;
  logic [2:0] win_reg, win_next;
  logic [fsp_pkg::IRQ_W-1:0] stat_reg, stat_next;
  logic [fsp_pkg::IRQ_W-1:0] mask_reg, mask_next;
  logic [fsp_pkg::REG_W-1:0] rdata_reg, rdata_next;
  // Operation group, power-on reset only
  fsp_pkg::fsp_op_t op_reg, op_next;
  logic [fsp_pkg::PAGE_W-1:0] page_reg, page_next;
  logic area_busy_reg, area_busy_next;
  logic halt_reg, halt_next;
  logic go_reg, go_next;
  logic [fsp_pkg::LOCK_W-1:0] lock_reg, lock_next;
  logic [fsp_pkg::LOCK_W-1:0] lockval_reg, lockval_next;
  // Output group, CPU reset; page buffer data has no reset
  logic fetch_ok_reg, fetch_ok_next;
  logic [fsp_pkg::REG_W-1:0] tbl_byte_reg, tbl_byte_next;
  logic [fsp_pkg::PC_W-1:0] boot_start_reg, boot_start_next;
  logic [fsp_pkg::PC_W-1:0] app_end_reg, app_end_next;
  logic spm_irq_reg, spm_irq_next;
  logic irq_reg, irq_next;
  logic [fsp_pkg::DATA_W-1:0] buf_data_reg;
  logic [fsp_pkg::DATA_W-1:0] buf_mem [fsp_pkg::BUF_DEPTH];

  logic timer_busy, timer_done;
  logic ctrl_wr, spm_fire, fill_fire, reen_fire, start, win_expire;
  fsp_pkg::fsp_op_t start_op;
  logic [fsp_pkg::PAGE_W-1:0] z_page;
  logic [fsp_pkg::WORD_W-1:0] z_word;

  assign z_page = z_ptr[fsp_pkg::Z_PAGE_HI:fsp_pkg::Z_PAGE_LO];
  assign z_word = z_ptr[fsp_pkg::Z_WORD_HI:fsp_pkg::Z_WORD_LO];
  // Command writes during an EEPROM write or a pending command are dropped; IE still updates
  assign ctrl_wr = reg_wr && (reg_addr == fsp_pkg::ADDR_CTRL);
  assign spm_fire = spm_exec && (win_reg != 3'h0) && cmd_reg[fsp_pkg::CTL_EN] && !timer_busy;
  assign fill_fire = spm_fire && (cmd_reg == fsp_pkg::CMD_FILL);
  assign reen_fire = spm_fire && (cmd_reg == fsp_pkg::CMD_REEN);
  assign win_expire = (win_reg == 3'h1) && !spm_fire;

  always_comb begin
    start_op = fsp_pkg::FSP_OP_NONE;
    if (spm_fire) begin
      case (cmd_reg)
        fsp_pkg::CMD_ERASE: start_op = fsp_pkg::FSP_OP_ERASE;
        fsp_pkg::CMD_WRITE: start_op = fsp_pkg::FSP_OP_WRITE;
        fsp_pkg::CMD_LOCK: start_op = fsp_pkg::FSP_OP_LOCK;
        default: start_op = fsp_pkg::FSP_OP_NONE;
      endcase
    end
  end
  assign start = (start_op != fsp_pkg::FSP_OP_NONE);

  fsp_prog_timer #(.TICKS(PROG_TICKS)) u_timer (
    .clock(clock),
    .por_n(por_n),
    .start(start),
    .rc_tick(rc_tick),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Control register, command window and interrupt registers
  always_comb begin
    cmd_next = cmd_reg;
    ie_next = ie_reg;
    win_next = win_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    rdata_next = '0;
    if (ctrl_wr) begin
      ie_next = reg_wdata[fsp_pkg::CTL_IE];
    end
    // A refused write must not stall the window countdown
    if (ctrl_wr && !cmd_reg[fsp_pkg::CTL_EN] && !eeprom_write_pending) begin
      cmd_next = reg_wdata[fsp_pkg::CMD_W-1:0];
      win_next = reg_wdata[fsp_pkg::CTL_EN] ? fsp_pkg::CMD_WINDOW : 3'h0;
    end else if (spm_fire) begin
      win_next = 3'h0;
      // Timed commands keep enable high until the timer ends
      if (!start) begin
        cmd_next = '0;
      end
    end else if (win_reg != 3'h0) begin
      win_next = win_reg - 3'h1;
      if (win_expire) begin
        cmd_next = '0;
      end
    end
    if (timer_done) begin
      cmd_next = '0;
    end
    if (reg_wr && (reg_addr == fsp_pkg::ADDR_IRQ_MASK)) begin
      mask_next = reg_wdata[fsp_pkg::IRQ_W-1:0];
    end
    if (reg_wr && (reg_addr == fsp_pkg::ADDR_IRQ_STAT)) begin
      stat_next = stat_reg & ~reg_wdata[fsp_pkg::IRQ_W-1:0];
    end
    // Set after clear so a same-cycle event survives
    stat_next[fsp_pkg::IRQ_DONE] = stat_next[fsp_pkg::IRQ_DONE] | timer_done;
    stat_next[fsp_pkg::IRQ_TIMEOUT] = stat_next[fsp_pkg::IRQ_TIMEOUT] | win_expire;
    if (reg_rd) begin
      case (reg_addr)
        fsp_pkg::ADDR_CTRL: rdata_next = {ie_reg, area_busy_reg, cmd_reg};
        fsp_pkg::ADDR_IRQ_STAT: rdata_next = {{(fsp_pkg::REG_W - fsp_pkg::IRQ_W){1'b0}}, stat_reg};
        fsp_pkg::ADDR_IRQ_MASK: rdata_next = {{(fsp_pkg::REG_W - fsp_pkg::IRQ_W){1'b0}}, mask_reg};
        fsp_pkg::ADDR_STATE: rdata_next = {lock_reg, 2'h0, halt_reg, timer_busy};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= '0;
      ie_reg <= 1'b0;
      win_reg <= 3'h0;
      stat_reg <= '0;
      mask_reg <= '0;
      rdata_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
      ie_reg <= ie_next;
      win_reg <= win_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
    end
  end

  // Operation state survives a CPU reset
  always_comb begin
    op_next = op_reg;
    page_next = page_reg;
    area_busy_next = area_busy_reg;
    halt_next = halt_reg;
    lock_next = lock_reg;
    lockval_next = lockval_reg;
    go_next = 1'b0;
    if (start) begin
      op_next = start_op;
      page_next = z_page;
      go_next = 1'b1;
      lockval_next = r1r0[fsp_pkg::LOCK_LSB +: fsp_pkg::LOCK_W];
      if (start_op != fsp_pkg::FSP_OP_LOCK) begin
        if (z_page < fsp_pkg::RWW_PAGES) begin
          area_busy_next = 1'b1;
        end else begin
          halt_next = 1'b1;
        end
      end
    end
    if (timer_done) begin
      op_next = fsp_pkg::FSP_OP_NONE;
      halt_next = 1'b0;
      if (op_reg == fsp_pkg::FSP_OP_LOCK) begin
        lock_next = lock_reg & lockval_reg;
      end
    end
    if (reen_fire) begin
      area_busy_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      op_reg <= fsp_pkg::FSP_OP_NONE;
      page_reg <= '0;
      area_busy_reg <= 1'b0;
      halt_reg <= 1'b0;
      go_reg <= 1'b0;
      lock_reg <= fsp_pkg::LOCK_RESET;
      lockval_reg <= fsp_pkg::LOCK_RESET;
    end else begin
      op_reg <= op_next;
      page_reg <= page_next;
      area_busy_reg <= area_busy_next;
      halt_reg <= halt_next;
      go_reg <= go_next;
      lock_reg <= lock_next;
      lockval_reg <= lockval_next;
    end
  end

  // Page buffer, no reset needed on data
  always_ff @(posedge clock) begin
    if (fill_fire) begin
      buf_mem[z_word] <= r1r0;
    end
    buf_data_reg <= buf_mem[buf_idx];
  end

  // Registered side outputs
  always_comb begin
    fetch_ok_next = 1'b1;
    if ((area_busy_reg || (timer_busy && (op_reg != fsp_pkg::FSP_OP_LOCK)))
        && (fetch_addr <= fsp_pkg::RWW_END)) begin
      fetch_ok_next = 1'b0;
    end
    tbl_byte_next = z_ptr[fsp_pkg::Z_BYTE] ? tbl_word[15:8] : tbl_word[7:0];
    case (boot_size)
      fsp_pkg::BOOT_SZ_256: boot_start_next = fsp_pkg::BOOT_START_256;
      fsp_pkg::BOOT_SZ_512: boot_start_next = fsp_pkg::BOOT_START_512;
      fsp_pkg::BOOT_SZ_1024: boot_start_next = fsp_pkg::BOOT_START_1024;
      default: boot_start_next = fsp_pkg::BOOT_START_2048;
    endcase
    app_end_next = boot_start_next - fsp_pkg::ADDR_ONE;
    spm_irq_next = ie_reg && !cmd_reg[fsp_pkg::CTL_EN];
    irq_next = |(stat_reg & mask_reg);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fetch_ok_reg <= 1'b0;
      tbl_byte_reg <= '0;
      boot_start_reg <= fsp_pkg::BOOT_START_2048;
      app_end_reg <= fsp_pkg::RWW_END;
      spm_irq_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      fetch_ok_reg <= fetch_ok_next;
      tbl_byte_reg <= tbl_byte_next;
      boot_start_reg <= boot_start_next;
      app_end_reg <= app_end_next;
      spm_irq_reg <= spm_irq_next;
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign fetch_ok = fetch_ok_reg;
  assign cpu_halt = halt_reg;
  assign tbl_byte = tbl_byte_reg;
  assign boot_start = boot_start_reg;
  assign app_end = app_end_reg;
  assign flash_op = op_reg;
  assign flash_page = page_reg;
  assign flash_go = go_reg;
  assign buf_data = buf_data_reg;
  assign lock_bits = lock_reg;
  assign spm_irq = spm_irq_reg;
  assign irq = irq_reg;

  // Helpers for checks only
  logic [fsp_pkg::Z_W-1:0] zp_q;
  logic [fsp_pkg::DATA_W-1:0] fill_data_q;
  always_ff @(posedge clock) begin
    zp_q <= z_ptr;
    fill_data_q <= r1r0;
  end

  a_window_expire: assert property (@(posedge clock) disable iff (!arst_n)
    (cmd_reg[fsp_pkg::CTL_EN] && (win_reg == fsp_pkg::CMD_WINDOW) && !timer_busy) ##0 (!spm_exec)[*4]
      |=> !cmd_reg[fsp_pkg::CTL_EN])
    else $error("command survived its window");
  a_done_clears: assert property (@(posedge clock) disable iff (!arst_n)
    timer_done |=> !cmd_reg[fsp_pkg::CTL_EN])
    else $error("enable not cleared after completion");
  a_irq_level: assert property (@(posedge clock) disable iff (!arst_n)
    (ie_reg && !cmd_reg[fsp_pkg::CTL_EN]) ##1 (ie_reg && !cmd_reg[fsp_pkg::CTL_EN]) |-> spm_irq)
    else $error("self-program interrupt not requested");
  a_area_hold: assert property (@(posedge clock) disable iff (!por_n)
    (area_busy_reg && !reen_fire) |=> area_busy_reg)
    else $error("area busy dropped without re-enable");
  a_area_clear: assert property (@(posedge clock) disable iff (!por_n)
    $fell(area_busy_reg) |-> $past(reen_fire && !timer_busy))
    else $error("area busy cleared wrongly");
  a_fetch_block: assert property (@(posedge clock) disable iff (!arst_n)
    (area_busy_reg && (fetch_addr <= fsp_pkg::RWW_END)) |=> !fetch_ok)
    else $error("busy area readable");
  a_page_map: assert property (@(posedge clock) disable iff (!por_n)
    start |=> (flash_go && (flash_page == zp_q[fsp_pkg::Z_PAGE_HI:fsp_pkg::Z_PAGE_LO])))
    else $error("wrong page taken from pointer");
  a_fill_index: assert property (@(posedge clock) disable iff (!arst_n)
    fill_fire |=> (buf_mem[zp_q[fsp_pkg::Z_WORD_HI:fsp_pkg::Z_WORD_LO]] == fill_data_q))
    else $error("buffer fill missed its word");
  a_boot_map: assert property (@(posedge clock) disable iff (!arst_n)
    (boot_size == fsp_pkg::BOOT_SZ_512) |=> ((boot_start == 13'h1e00) && (app_end == 13'h1dff)))
    else $error("boot map wrong");
  a_reset_survive: assert property (@(posedge clock) disable iff (!por_n)
    (timer_busy && !arst_n) |=> (timer_busy || timer_done))
    else $error("write cut short by reset");
  a_halt_no_read_while_write_area: assert property (@(posedge clock) disable iff (!por_n)
    (start && (start_op != fsp_pkg::FSP_OP_LOCK) && (z_page >= fsp_pkg::RWW_PAGES)) |=> cpu_halt)
    else $error("CPU not halted for upper area");
endmodule : fsp_ctrl

// >>> dv/fsp_cpu_model.sv
// Purpose: CPU core model that issues register accesses and store-to-program instructions.
// Assumes: All outputs change by non-blocking assignment just after a rising edge.
// Notes: A command first polls until enable is clear and no EEPROM write is pending.
`timescale 1ns/10ps
module fsp_cpu_model (
  input wire logic clock,
  input wire logic eeprom_write_pending,
  input wire logic [fsp_pkg::REG_W-1:0] reg_rdata,
  output logic [fsp_pkg::ADDR_W-1:0] reg_addr,
  output logic [fsp_pkg::REG_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic spm_exec
);
  // Set when a command poll runs out; the bench counts it as a mismatch
  logic stuck;
  initial begin
    stuck = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    spm_exec = 1'b0;
  end
  task automatic wr(input logic [fsp_pkg::ADDR_W-1:0] a, input logic [fsp_pkg::REG_W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [fsp_pkg::ADDR_W-1:0] a, output logic [fsp_pkg::REG_W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Without go the instruction is withheld, letting the command window lapse
  task automatic cmd(input logic [fsp_pkg::REG_W-1:0] d, input logic go);
    logic [fsp_pkg::REG_W-1:0] s;
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      rd(fsp_pkg::ADDR_CTRL, s);
      ok = (s[fsp_pkg::CTL_EN] === 1'b0) && (eeprom_write_pending === 1'b0);
    end
    if (!ok) begin
      stuck = 1'b1;
    end
    wr(fsp_pkg::ADDR_CTRL, d);
    spm_exec <= go;
    @(posedge clock);
    spm_exec <= 1'b0;
  endtask : cmd
endmodule : fsp_cpu_model

// >>> dv/test_flash_self_program_control.sv
// Purpose: Self-checking bench for the flash self-programming controller.
// Assumes: Eight RC ticks per timed op; RC tick every 12.5 clocks on average.
// Notes: Op length is checked in clocks derived from the tick rate.
`timescale 1ns/10ps
module test_flash_self_program_control;
  localparam int TICKS = 8;
  logic clock = 0, arst_n = 0, por_n = 0, rc_tick = 0, run_rc = 1, eeprom_write_pending = 0;
  logic [15:0] z_ptr = 0, r1r0 = 0, tbl_word = 0;
  logic [1:0] boot_size = 0;
  logic [12:0] fetch_addr = 0;
  logic [5:0] buf_idx = 0;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tbl_byte;
  logic reg_wr, reg_rd, spm_exec, fetch_ok, cpu_halt, flash_go, spm_irq, irq;
  logic [12:0] boot_start, app_end;
  logic [1:0] flash_op;
  logic [6:0] flash_page;
  logic [15:0] buf_data;
  logic [3:0] lock_bits;
  logic [4:0] rc_cnt = 0;
  int cyc = 0, go_cyc = 0, checks = 0, err_count = 0;
  logic [12:0] boot_tab [4] = '{13'h1800, 13'h1c00, 13'h1e00, 13'h1f00};

  always #5 clock = ~clock;
  // Ticks at 0 and 12 of 25 clocks give the 12.5-clock RC period
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rc_cnt <= (rc_cnt == 5'd24) ? 5'd0 : rc_cnt + 5'd1;
    rc_tick <= run_rc && (rc_cnt == 5'd0 || rc_cnt == 5'd12);
    if (flash_go === 1'b1) go_cyc <= cyc;
  end

  fsp_cpu_model u_cpu (.clock(clock), .eeprom_write_pending(eeprom_write_pending), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .spm_exec(spm_exec));
  fsp_ctrl #(.PROG_TICKS(TICKS)) u_dut (.clock(clock), .arst_n(arst_n), .por_n(por_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .eeprom_write_pending(eeprom_write_pending), .spm_exec(spm_exec), .z_ptr(z_ptr), .r1r0(r1r0),
    .rc_tick(rc_tick), .boot_size(boot_size), .fetch_addr(fetch_addr), .fetch_ok(fetch_ok),
    .cpu_halt(cpu_halt), .tbl_word(tbl_word), .tbl_byte(tbl_byte), .boot_start(boot_start),
    .app_end(app_end), .flash_op(flash_op), .flash_page(flash_page), .flash_go(flash_go),
    .buf_idx(buf_idx), .buf_data(buf_data), .lock_bits(lock_bits), .spm_irq(spm_irq), .irq(irq));

  task automatic results();
    if (u_cpu.stuck !== 1'b0) begin
      $display("ERROR cmd_poll expected idle seen busy");
      err_count++;
    end
    $display("Checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    u_cpu.rd(a, d);
    chk(n, e, d);
  endtask : rdc
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic wait_op();
    for (int i = 0; i < 600; i++) begin
      @(posedge clock);
      #1;
      if (flash_op === 2'h0) return;
    end
    $display("ERROR wait_op expected idle seen busy");
    err_count++;
    results();
  endtask : wait_op
  task automatic done_test(input string n);
    $display("Test %s done", n);
  endtask : done_test

  initial begin
    step(16);
    chk("rdata_rst", 0, reg_rdata);
    chk("irq_rst", 0, {spm_irq, irq});
    @(posedge clock) begin
      por_n <= 1;
      arst_n <= 1;
    end
    rdc(fsp_pkg::ADDR_STATE, 8'hf0, "state_rst");
    rdc(fsp_pkg::ADDR_CTRL, 8'h00, "ctrl_rst");
    rdc(3'h6, 8'h00, "unmapped");
    done_test("reset");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) boot_size <= i[1:0];
      step(2);
      chk("boot_start", boot_tab[i], boot_start);
      chk("app_end", boot_tab[i] - 13'h1, app_end);
    end
    done_test("boot_size");
    // Last word of the page, pointer bit 0 kept zero
    @(posedge clock) begin
      z_ptr <= {9'h0, 6'h3f, 1'b0};
      r1r0 <= 16'ha5c3;
    end
    u_cpu.cmd(8'h01, 1'b1);
    @(posedge clock) buf_idx <= 6'h3f;
    step(1);
    chk("buf_data", 16'ha5c3, buf_data);
    done_test("fill");
    @(posedge clock) begin
      z_ptr <= 16'h0280;
      fetch_addr <= 13'h0140;
    end
    u_cpu.cmd(8'h03, 1'b1);
    #1 chk("go", 1, flash_go);
    chk("op_erase", 1, flash_op);
    chk("page", 5, flash_page);
    step(2);
    chk("fetch_rww", 0, fetch_ok);
    @(posedge clock) fetch_addr <= 13'h1800;
    step(2);
    chk("fetch_no_read_while_write_area", 1, fetch_ok);
    rdc(fsp_pkg::ADDR_CTRL, 8'h43, "ctrl_busy");
    wait_op();
    chk("dur_lo", 1, (cyc - go_cyc) >= 87);
    chk("dur_hi", 1, (cyc - go_cyc) <= 110);
    rdc(fsp_pkg::ADDR_CTRL, 8'h40, "ctrl_done");
    rdc(fsp_pkg::ADDR_IRQ_STAT, 8'h01, "stat_done");
    chk("irq_masked", 0, irq);
    u_cpu.wr(fsp_pkg::ADDR_IRQ_MASK, 8'h01);
    step(2);
    chk("irq_on", 1, irq);
    u_cpu.wr(fsp_pkg::ADDR_IRQ_STAT, 8'h01);
    step(2);
    chk("irq_clr", 0, irq);
    u_cpu.cmd(8'h11, 1'b1);
    rdc(fsp_pkg::ADDR_CTRL, 8'h00, "reenable");
    @(posedge clock) fetch_addr <= 13'h0140;
    step(2);
    chk("fetch_back", 1, fetch_ok);
    done_test("erase");
    @(posedge clock) z_ptr <= 16'h3000;
    u_cpu.cmd(8'h05, 1'b1);
    #1 chk("op_write", 2, flash_op);
    chk("page_no_read_while_write_area", 7'h60, flash_page);
    step(1);
    chk("halt", 1, cpu_halt);
    // Stalled RC ticks and a CPU reset must both leave the write running
    run_rc <= 0;
    @(posedge clock) arst_n <= 0;
    step(3);
    @(posedge clock) arst_n <= 1;
    step(150);
    chk("op_kept", 2, flash_op);
    run_rc <= 1;
    wait_op();
    chk("halt_end", 0, cpu_halt);
    done_test("write_reset");
    u_cpu.wr(fsp_pkg::ADDR_IRQ_STAT, 8'h03);
    u_cpu.cmd(8'h03, 1'b0);
    u_cpu.wr(fsp_pkg::ADDR_CTRL, 8'h00);
    step(6);
    rdc(fsp_pkg::ADDR_CTRL, 8'h00, "lapsed");
    rdc(fsp_pkg::ADDR_IRQ_STAT, 8'h02, "stat_tmo");
    chk("op_none", 0, flash_op);
    @(posedge clock) eeprom_write_pending <= 1;
    u_cpu.wr(fsp_pkg::ADDR_CTRL, 8'h03);
    rdc(fsp_pkg::ADDR_CTRL, 8'h00, "ee_block");
    @(posedge clock) eeprom_write_pending <= 0;
    done_test("timeout");
    @(posedge clock) begin
      z_ptr <= 16'h0000;
      r1r0 <= 16'h00e3;
    end
    u_cpu.cmd(8'h09, 1'b1);
    #1 chk("op_lock", 3, flash_op);
    wait_op();
    step(2);
    chk("lock_bits", 4'h8, lock_bits);
    done_test("lock");
    u_cpu.wr(fsp_pkg::ADDR_CTRL, 8'h80);
    step(2);
    chk("spm_irq", 1, spm_irq);
    @(posedge clock) begin
      tbl_word <= 16'hbeef;
      z_ptr <= 16'h0001;
    end
    step(2);
    chk("tbl_hi", 8'hbe, tbl_byte);
    @(posedge clock) z_ptr <= 16'h0000;
    step(2);
    chk("tbl_lo", 8'hef, tbl_byte);
    done_test("irq_table");
    results();
  end
endmodule : test_flash_self_program_control
